// ---- imc_pkg.sv ----
// constants, types and state layout of the i2c master control and status block
`default_nettype none
package imc_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_RXDATA = 4'h4;
  localparam logic [3:0] OFS_TXDATA = 4'h8;
  localparam logic [3:0] OFS_CMD = 4'hC;
  localparam int BIT_RXF = 7;
  localparam int BIT_RX_FULL_IRQ_EN = 6;
  localparam int BIT_ERR = 5;
  localparam int BIT_RATE = 4;
  localparam int BIT_TXE = 3;
  localparam int BIT_TX_EMPTY_IRQ_EN = 2;
  localparam int BIT_STOP_AFTER_READ = 1;
  localparam int BIT_STOP_AFTER_WRITE = 0;
  localparam int BIT_CMD_READ = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ****************************************
  // timing and buffering
  // ****************************************
  localparam int CLK_MHZ = 250;
  localparam int STD_RATE_KHZ = 100;
  localparam int FAST_RATE_KHZ = 400;
  localparam logic [9:0] QUARTER_STD_CYC = 10'(CLK_MHZ * 1000 / (STD_RATE_KHZ * 4));
  localparam logic [9:0] QUARTER_FAST_CYC = 10'(CLK_MHZ * 1000 / (FAST_RATE_KHZ * 4));
  localparam int FIFO_WIDTH = 9;
  localparam int FIFO_DEPTH = 16;

  // ****************************************
  // engine states and block state
  // ****************************************
  typedef enum logic [4:0] {
    ENG_IDLE = 5'h01,
    ENG_START = 5'h02,
    ENG_BIT = 5'h04,
    ENG_ACK = 5'h08,
    ENG_STOP = 5'h10
  } imc_eng_t;

  typedef struct packed {
    logic waitReq;
    logic [31:0] readData;
    logic rx_full_flag;
    logic rx_full_irq_en;
    logic err;
    logic rate;
    logic tx_empty_flag;
    logic tx_empty_irq_en;
    logic stopRd;
    logic stopWr;
    logic [7:0] rxData;
    imc_eng_t eng;
    logic [1:0] phase;
    logic [2:0] bitCnt;
    logic [7:0] shift;
    logic isRead;
    logic nack;
    logic onBus;
    logic [9:0] tickCnt;
    logic sync1;
    logic sync2;
    logic sclOe;
    logic sdaOe;
    logic sclOut;
    logic sdaOut;
    logic irq;
  } imc_state_t;

endpackage
`default_nettype wire

// ---- imc_ctrl_top.sv ----
// i2c master port: command fifo, register slave, byte engine and flags
`timescale 1ns/1ns
`default_nettype none

// ****************************************
// command fifo
// ****************************************
module imc_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0] count;
  } imc_fifo_state_t;

  imc_fifo_state_t s;
  imc_fifo_state_t next_s;
  logic doPush;
  logic doPop;

  // flags come from the count so full and empty never disagree
  assign inReady = (s.count != FULL_CNT);
  assign outValid = (s.count != '0);
  assign outData = s.mem[s.rdPtr];

  // push and pop may happen in the same cycle
  always_comb begin
    next_s = s;
    doPush = inValid && inReady;
    doPop = outValid && outReady;
    if (doPush) begin
      next_s.mem[s.wrPtr] = inData;
      next_s.wrPtr = s.wrPtr + 1'b1;
    end
    if (doPop) begin
      next_s.rdPtr = s.rdPtr + 1'b1;
    end
    if (doPush && !doPop) begin
      next_s.count = s.count + 1'b1;
    end else if (doPop && !doPush) begin
      next_s.count = s.count - 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule

// ****************************************
// top: register slave and serial engine
// ****************************************
module imc_ctrl_top (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [3:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  input wire logic [3:0] avsByteEnable,
  output logic [31:0] avsReadData,
  output logic avsWaitRequest,
  output logic sclOut,
  output logic sclOe,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  output logic irq
);
  imc_pkg::imc_state_t s;
  imc_pkg::imc_state_t next_s;
  logic fifoInValid;
  logic fifoInReady;
  logic [8:0] fifoInData;
  logic fifoOutValid;
  logic fifoOutReady;
  logic [8:0] fifoOutData;
  logic tick;
  logic [9:0] reload;
  logic ctrlWrAck;
  logic txWrAck;
  logic rxRdAck;
  logic rxDone;
  logic txDone;
  logic stopNow;
  logic [7:0] ctrlView;

  assign avsReadData = s.readData;
  assign avsWaitRequest = s.waitReq;
  assign sclOut = s.sclOut;
  assign sclOe = s.sclOe;
  assign sdaOut = s.sdaOut;
  assign sdaOe = s.sdaOe;
  assign irq = s.irq;

  // bit 8 marks a read request, low byte is the byte to send
  imc_fifo #(
    .WIDTH(imc_pkg::FIFO_WIDTH),
    .DEPTH(imc_pkg::FIFO_DEPTH)
  ) cmdFifo (
    .core_clk(core_clk),
    .nrst(nrst),
    .inValid(fifoInValid),
    .inReady(fifoInReady),
    .inData(fifoInData),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady),
    .outData(fifoOutData)
  );

  // whole next state; bus effects first so hardware sets below win
  always_comb begin
    next_s = s;
    fifoInValid = 1'b0;
    fifoInData = '0;
    fifoOutReady = 1'b0;
    ctrlWrAck = 1'b0;
    txWrAck = 1'b0;
    rxRdAck = 1'b0;
    rxDone = 1'b0;
    txDone = 1'b0;
    stopNow = 1'b0;
    ctrlView = {s.rx_full_flag, s.rx_full_irq_en, s.err, s.rate, s.tx_empty_flag, s.tx_empty_irq_en, s.stopRd, s.stopWr};
    reload = s.rate ? imc_pkg::QUARTER_FAST_CYC - 10'h001 :
      imc_pkg::QUARTER_STD_CYC - 10'h001;
    tick = (s.tickCnt == 10'h000);
    next_s.sync1 = sdaIn;
    next_s.sync2 = s.sync1;

    // avalon slave: one wait cycle, then a single low cycle of waitrequest
    if (!s.waitReq) begin
      next_s.waitReq = 1'b1;
    end else if (avsRead || avsWrite) begin
      // a full fifo stalls any write that would push into it, so no request is lost
      if (!(avsWrite && avsByteEnable[0] && !fifoInReady &&
            (avsAddress == imc_pkg::OFS_TXDATA || avsAddress == imc_pkg::OFS_CMD))) begin
        next_s.waitReq = 1'b0;
        next_s.readData = '0;
        if (avsRead) begin
          case (avsAddress)
            imc_pkg::OFS_CTRL: begin
              next_s.readData = {24'h000000, ctrlView};
            end
            imc_pkg::OFS_RXDATA: begin
              next_s.readData = {24'h000000, s.rxData};
              rxRdAck = 1'b1;
              next_s.rx_full_flag = 1'b0;
            end
            default: begin
              next_s.readData = '0;
            end
          endcase
        end else if (avsByteEnable[0]) begin
          case (avsAddress)
            imc_pkg::OFS_CTRL: begin
              ctrlWrAck = 1'b1;
              next_s.rx_full_irq_en = avsWriteData[imc_pkg::BIT_RX_FULL_IRQ_EN];
              next_s.err = avsWriteData[imc_pkg::BIT_ERR];
              next_s.rate = avsWriteData[imc_pkg::BIT_RATE];
              next_s.tx_empty_irq_en = avsWriteData[imc_pkg::BIT_TX_EMPTY_IRQ_EN];
              next_s.stopRd = avsWriteData[imc_pkg::BIT_STOP_AFTER_READ];
              next_s.stopWr = avsWriteData[imc_pkg::BIT_STOP_AFTER_WRITE];
            end
            imc_pkg::OFS_TXDATA: begin
              txWrAck = 1'b1;
              fifoInValid = 1'b1;
              fifoInData = {1'b0, avsWriteData[7:0]};
              next_s.tx_empty_flag = 1'b0;
            end
            imc_pkg::OFS_CMD: begin
              // a read request queues behind pending transmit bytes
              fifoInValid = avsWriteData[imc_pkg::BIT_CMD_READ];
              fifoInData = 9'h100;
            end
            default: begin
              fifoInValid = 1'b0;
            end
          endcase
        end
      end
    end

    // quarter-bit divider, held at reload while idle
    if (s.eng == imc_pkg::ENG_IDLE) begin
      next_s.tickCnt = reload;
    end else begin
      next_s.tickCnt = tick ? reload : s.tickCnt - 10'h001;
    end
    if (s.eng != imc_pkg::ENG_IDLE && tick) begin
      next_s.phase = s.phase + 2'h1;
    end

    // byte engine: four quarter phases per bit, scl low, high, high, low
    case (s.eng)
      imc_pkg::ENG_IDLE: begin
        if (fifoOutValid) begin
          fifoOutReady = 1'b1;
          next_s.isRead = fifoOutData[8];
          next_s.shift = fifoOutData[7:0];
          next_s.bitCnt = 3'h0;
          next_s.phase = 2'h0;
          next_s.nack = 1'b0;
          next_s.eng = s.onBus ? imc_pkg::ENG_BIT : imc_pkg::ENG_START;
        end
      end
      imc_pkg::ENG_START: begin
        if (tick) begin
          case (s.phase)
            2'h0: begin
              next_s.sclOe = 1'b0;
              next_s.sdaOe = 1'b0;
            end
            2'h1: next_s.sdaOe = 1'b1;
            2'h2: next_s.sclOe = 1'b1;
            default: begin
              next_s.onBus = 1'b1;
              next_s.eng = imc_pkg::ENG_BIT;
            end
          endcase
        end
      end
      imc_pkg::ENG_BIT: begin
        if (tick) begin
          case (s.phase)
            2'h0: next_s.sdaOe = !s.isRead && !s.shift[7];
            2'h1: next_s.sclOe = 1'b0;
            2'h2: begin
              if (s.isRead) begin
                next_s.shift = {s.shift[6:0], s.sync2};
              end
            end
            default: begin
              next_s.sclOe = 1'b1;
              next_s.bitCnt = s.bitCnt + 3'h1;
              if (!s.isRead) begin
                next_s.shift = {s.shift[6:0], 1'b0};
              end
              if (s.bitCnt == 3'h7) begin
                next_s.eng = imc_pkg::ENG_ACK;
              end
            end
          endcase
        end
      end
      imc_pkg::ENG_ACK: begin
        if (tick) begin
          case (s.phase)
            // the last read byte is answered with no acknowledge
            2'h0: next_s.sdaOe = s.isRead && !s.stopRd;
            2'h1: next_s.sclOe = 1'b0;
            2'h2: begin
              if (!s.isRead && s.sync2) begin
                next_s.nack = 1'b1;
                next_s.err = 1'b1;
              end
            end
            default: begin
              next_s.sclOe = 1'b1;
              next_s.sdaOe = 1'b0;
              if (s.isRead) begin
                rxDone = 1'b1;
                next_s.rxData = s.shift;
                next_s.rx_full_flag = 1'b1;
                stopNow = s.stopRd;
              end else begin
                txDone = 1'b1;
                next_s.tx_empty_flag = 1'b1;
                stopNow = s.stopWr || s.nack;
              end
              next_s.eng = stopNow ? imc_pkg::ENG_STOP : imc_pkg::ENG_IDLE;
            end
          endcase
        end
      end
      imc_pkg::ENG_STOP: begin
        if (tick) begin
          case (s.phase)
            2'h0: next_s.sdaOe = 1'b1;
            2'h1: next_s.sclOe = 1'b0;
            2'h2: next_s.sdaOe = 1'b0;
            default: begin
              next_s.onBus = 1'b0;
              next_s.eng = imc_pkg::ENG_IDLE;
            end
          endcase
        end
      end
      default: begin
        next_s.eng = imc_pkg::ENG_IDLE;
      end
    endcase

    // one request line for both flags, each behind its own enable
    next_s.irq = (s.rx_full_flag && s.rx_full_irq_en) || (s.tx_empty_flag && s.tx_empty_irq_en);
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
      s.waitReq <= 1'b1;
      s.eng <= imc_pkg::ENG_IDLE;
      s.tickCnt <= imc_pkg::QUARTER_STD_CYC - 10'h001;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  irq_rx_on_a: assert property (s.rx_full_flag && s.rx_full_irq_en |=> irq)
    else $error("receive-full request missing");
  irq_tx_on_a: assert property (s.tx_empty_flag && s.tx_empty_irq_en |=> irq)
    else $error("transmit-empty request missing");
  irq_gated_a: assert property (!(s.rx_full_flag && s.rx_full_irq_en) && !(s.tx_empty_flag && s.tx_empty_irq_en) |=> !irq)
    else $error("interrupt raised while gated");
  err_on_nack_a: assert property (s.eng == imc_pkg::ENG_ACK && tick && s.phase == 2'h2 &&
    !s.isRead && s.sync2 |=> s.err)
    else $error("no acknowledge did not set error");
  err_sticky_a: assert property (s.err && !(ctrlWrAck && !avsWriteData[imc_pkg::BIT_ERR])
    |=> s.err)
    else $error("error flag cleared without software");
  rate_fast_a: assert property (s.eng != imc_pkg::ENG_IDLE && tick && s.rate
    |=> s.tickCnt == imc_pkg::QUARTER_FAST_CYC - 10'h001)
    else $error("fast rate reload wrong");
  stop_read_a: assert property (rxDone && s.stopRd |=> s.eng == imc_pkg::ENG_STOP)
    else $error("stop missing after read byte");
  stop_write_a: assert property (txDone && s.stopWr |=> s.eng == imc_pkg::ENG_STOP)
    else $error("stop missing after write byte");
  rxf_clear_a: assert property (rxRdAck && !rxDone |=> !s.rx_full_flag)
    else $error("receive-full not cleared by read");
  txe_clear_a: assert property (txWrAck && !txDone |=> !s.tx_empty_flag)
    else $error("transmit-empty not cleared by write");
  rx_byte_a: assert property (rxDone |=> s.rx_full_flag && s.rxData == $past(s.shift))
    else $error("receive byte not refreshed");
endmodule

`default_nettype wire

// ---- imc_slave_model.sv ----
// i2c slave partner model on the open-drain serial lines
`timescale 1ns/1ns
`default_nettype none
module imc_slave_model (
  input wire logic sclLine,
  input wire logic sdaLine,
  input wire logic ackEn,
  input wire logic [7:0] rdByte,
  output logic slvOe,
  output logic [7:0] gotByte,
  output int stopCnt
);
  int cnt = -1;
  logic rd = 1'b0;
  logic first = 1'b0;
  logic busy = 1'b0;
  logic quiet = 1'b0;
  logic [7:0] sh = 8'h00;
  logic [7:0] outB = 8'h00;
  initial begin
    slvOe = 1'b0;
    gotByte = 8'h00;
    stopCnt = 0;
  end
  // start and stop: sda moves while scl is high; stops count only after a start
  always @(sdaLine) begin
    if (sclLine === 1'b1) begin
      if (sdaLine && busy) stopCnt++;
      busy = !sdaLine;
      first = !sdaLine;
      cnt = -1;
      rd = 1'b0;
      quiet = 1'b0;
      slvOe = 1'b0;
    end
  end
  // rising scl: data bits, then the master's acknowledge
  always @(posedge sclLine) begin
    if (cnt >= 0 && cnt < 8) sh = {sh[6:0], sdaLine};
    if (cnt == 8 && rd && sdaLine) quiet = 1'b1; // master refused: go silent
  end
  // falling scl: sda only ever changes while scl is low
  always @(negedge sclLine) begin
    cnt = (cnt == 8) ? 0 : cnt + 1;
    if (cnt == 8 && !rd) begin
      gotByte = sh;
      slvOe = ackEn;
      rd = first && sh[0];
      first = 1'b0;
    end else if (rd && !quiet && cnt < 8) begin
      if (cnt == 0) outB = rdByte;
      slvOe = !outB[7 - cnt];
    end else begin
      slvOe = 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// self-checking bench for the i2c master control and status block
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin errTotal++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, exp, got); end end
module tb_top;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] avsAddress = 4'h0;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [31:0] avsWriteData = 32'h0;
  logic [3:0] avsByteEnable = 4'hF;
  logic [31:0] avsReadData;
  logic avsWaitRequest, sclOut, sclOe, sdaOut, sdaOe, irq, slvOe;
  logic ackEn = 1'b1;
  logic [7:0] rdByte = 8'h00;
  logic [7:0] gotByte, q, v;
  int stopCnt, errTotal = 0, comparisons = 0, hiCnt = 0, lastHi = 0;
  logic [31:0] seed = 32'hF9E0B597;
  // open-drain lines with pull-ups: low while anyone enables its driver
  wire logic sclLine = !sclOe;
  wire logic sdaLine = !(sdaOe || slvOe);
  imc_ctrl_top dut_u (.core_clk(core_clk), .nrst(nrst), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
    .avsByteEnable(avsByteEnable), .avsReadData(avsReadData),
    .avsWaitRequest(avsWaitRequest), .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sdaLine),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .irq(irq));
  imc_slave_model slv_u (.sclLine(sclLine), .sdaLine(sdaLine), .ackEn(ackEn),
    .rdByte(rdByte), .slvOe(slvOe), .gotByte(gotByte), .stopCnt(stopCnt));
  always #2 core_clk = !core_clk;
  // length of the last finished scl high phase, in clock cycles
  always @(posedge core_clk) begin
    if (sclLine) hiCnt <= hiCnt + 1;
    else if (hiCnt != 0) begin
      lastHi <= hiCnt;
      hiCnt <= 0;
    end
  end
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // scl is high for two quarter ticks of a bit slot; two cycles of slack each way
  function automatic logic hiOk(input int seen, input logic fast);
    int want;
    want = 2 * int'(fast ? imc_pkg::QUARTER_FAST_CYC : imc_pkg::QUARTER_STD_CYC);
    return (seen - want) inside {[-2:2]};
  endfunction
  // one avalon access; held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d,
    input logic [3:0] be);
    @(posedge core_clk);
    avsAddress <= a;
    avsWriteData <= {24'h0, d};
    avsByteEnable <= be;
    avsWrite <= wr;
    avsRead <= !wr;
    do @(posedge core_clk); while (avsWaitRequest !== 1'b0);
    q = avsReadData[7:0];
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
  endtask
  // poll the control register until a flag in the mask shows
  task automatic waitCtrl(input logic [7:0] m);
    for (int i = 0; i < 20000; i++) begin
      bus(1'b0, imc_pkg::OFS_CTRL, 8'h00, 4'hF);
      if ((q & m) != 8'h00) break;
    end
    `CHK("ctrl flag wait", m, q & m)
  endtask
  // a wait that runs out is counted as a mismatch
  task automatic waitStop(input int n);
    for (int i = 0; i < 5000 && stopCnt != n; i++) @(posedge core_clk);
    `CHK("stop wait", n, stopCnt)
  endtask
  task automatic results();
    if (errTotal == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // a hang counts as a mismatch; the whole run needs about 60k cycles
  initial begin
    repeat (100000) @(posedge core_clk);
    errTotal++;
    results();
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    bus(1'b0, imc_pkg::OFS_CTRL, 8'h00, 4'hF);
    `CHK("ctrl reset", imc_pkg::CTRL_RESET, q)
    `CHK("irq reset", 1'b0, irq)
    `CHK("lines idle", 4'h0, {sclOut, sdaOut, sclOe, sdaOe})
    bus(1'b0, 4'h2, 8'h00, 4'hF);
    `CHK("unmapped read", 8'h00, q)
    bus(1'b1, imc_pkg::OFS_CTRL, 8'hFF, 4'hF);
    bus(1'b0, imc_pkg::OFS_CTRL, 8'h00, 4'hF);
    `CHK("ctrl all ones", 8'h77, q)
    seed = lfsr(seed);
    v = seed[7:0] & 8'h77;
    bus(1'b1, imc_pkg::OFS_CTRL, v, 4'hF);
    bus(1'b1, imc_pkg::OFS_CTRL, ~v, 4'hE); // lane 0 off: must be ignored
    bus(1'b0, imc_pkg::OFS_CTRL, 8'h00, 4'hF);
    `CHK("ctrl random", v, q)
    // write: address byte, then one data byte closed by a stop at 400 kHz
    bus(1'b1, imc_pkg::OFS_CTRL, 8'h14, 4'hF);
    bus(1'b1, imc_pkg::OFS_TXDATA, 8'hA0, 4'hF);
    waitCtrl(8'h08);
    `CHK("addr byte", 8'hA0, gotByte)
    `CHK("tx irq", 1'b1, irq)
    seed = lfsr(seed);
    v = seed[7:0];
    bus(1'b1, imc_pkg::OFS_CTRL, 8'h15, 4'hF);
    bus(1'b1, imc_pkg::OFS_TXDATA, v, 4'hF);
    bus(1'b0, imc_pkg::OFS_CTRL, 8'h00, 4'hF);
    `CHK("txe cleared", 8'h00, q & 8'h08)
    waitCtrl(8'h08);
    `CHK("data byte", v, gotByte)
    `CHK("fast high", 1'b1, hiOk(lastHi, 1'b1))
    `CHK("no early stop", 0, stopCnt)
    waitStop(1);
    `CHK("stop after write", 1, stopCnt)
    bus(1'b1, imc_pkg::OFS_CTRL, 8'h14, 4'hF);
    // read: address with read bit, then one byte from the slave and a stop
    seed = lfsr(seed);
    rdByte <= seed[15:8];
    bus(1'b1, imc_pkg::OFS_TXDATA, 8'hA1, 4'hF);
    waitCtrl(8'h08);
    bus(1'b1, imc_pkg::OFS_CTRL, 8'h12, 4'hF);
    bus(1'b1, imc_pkg::OFS_CMD, 8'h01, 4'hF);
    waitCtrl(8'h80);
    `CHK("rx irq masked", 1'b0, irq)
    bus(1'b1, imc_pkg::OFS_CTRL, 8'h52, 4'hF);
    repeat (2) @(posedge core_clk);
    `CHK("rx irq", 1'b1, irq)
    waitStop(2);
    `CHK("stop after read", 2, stopCnt)
    bus(1'b0, imc_pkg::OFS_RXDATA, 8'h00, 4'hF);
    `CHK("rx byte", rdByte, q)
    bus(1'b0, imc_pkg::OFS_CTRL, 8'h00, 4'hF);
    `CHK("rxf cleared", 8'h00, q & 8'h80)
    bus(1'b1, imc_pkg::OFS_CTRL, 8'h10, 4'hF);
    // slave stays silent: error flag, stop, and the flag sticks until cleared
    ackEn <= 1'b0;
    bus(1'b1, imc_pkg::OFS_TXDATA, 8'hB0, 4'hF);
    waitCtrl(8'h20);
    `CHK("nack err", 8'h20, q & 8'h20)
    waitStop(3);
    `CHK("nack stop", 3, stopCnt)
    repeat (50) @(posedge core_clk);
    bus(1'b0, imc_pkg::OFS_CTRL, 8'h00, 4'hF);
    `CHK("err sticks", 8'h20, q & 8'h20)
    bus(1'b1, imc_pkg::OFS_CTRL, 8'h00, 4'hF);
    bus(1'b0, imc_pkg::OFS_CTRL, 8'h00, 4'hF);
    `CHK("err cleared", 8'h00, q & 8'h20)
    ackEn <= 1'b1;
    // standard rate: one byte with stop
    bus(1'b1, imc_pkg::OFS_CTRL, 8'h01, 4'hF);
    bus(1'b1, imc_pkg::OFS_TXDATA, seed[23:16] & 8'hFE, 4'hF);
    waitCtrl(8'h08);
    `CHK("std high", 1'b1, hiOk(lastHi, 1'b0))
    `CHK("std byte", seed[23:16] & 8'hFE, gotByte)
    waitStop(4);
    `CHK("std stop", 4, stopCnt)
    `CHK("lines released", 4'h0, {sclOut, sdaOut, sclOe, sdaOe})
    results();
  end
endmodule
`default_nettype wire
